// file: core/sfe_pkg.sv
package sfe_pkg;
  localparam logic [7:0] OP_PAGE_ERASE = 8'h81;
  localparam logic [7:0] OP_BLOCK_ERASE = 8'h50;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h7c;
  localparam int CMD_BITS = 32;
  localparam int PAGE_BITS = 11;
  // page number lsb position in 24-bit address field
  localparam int PG_LSB_264 = 9;
  localparam int PG_LSB_256 = 8;
  localparam int PAGES_PER_BLOCK = 8;
  localparam int PAGES_PER_SECTOR = 256;
  localparam int SECTOR0_PAGES = 8;
  localparam int CLK_MHZ = 100;
  // erase times in microseconds (plain defaults)
  localparam int PAGE_ERASE_TIME_US = 50;
  localparam int BLOCK_ERASE_TIME_US = 100;
  localparam int SECTOR_ERASE_TIME_US = 1000;
  localparam int PAGE_ERASE_CYC = PAGE_ERASE_TIME_US * CLK_MHZ;
  localparam int BLOCK_ERASE_CYC = BLOCK_ERASE_TIME_US * CLK_MHZ;
  localparam int SECTOR_ERASE_CYC = SECTOR_ERASE_TIME_US * CLK_MHZ;
  localparam int CNT_W = 24;

  typedef enum logic [1:0] {
    SFE_OP_NONE,
    SFE_OP_PAGE,
    SFE_OP_BLOCK,
    SFE_OP_SECTOR
  } sfe_op_type;

  typedef struct packed {
    sfe_op_type op;
    logic [PAGE_BITS-1:0] first_page;
    logic [PAGE_BITS:0] page_count;
  } sfe_job_type;
endpackage

// file: core/sfe_shift_in.sv
// samples the serial pins and assembles the command word
module sfe_shift_in (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  output logic [31:0] word_q,
  output logic [5:0] nbits_q,
  output logic cs_rise
);
  logic [1:0] sck_s_q, sck_s_d;
  logic [1:0] cs_s_q, cs_s_d;
  logic [1:0] si_s_q, si_s_d;
  logic sck_old_q, sck_old_d;
  logic cs_old_q, cs_old_d;
  logic [31:0] word_d;
  logic [5:0] nbits_d;

  always_comb begin
    sck_s_d = {sck_s_q[0], sck};
    cs_s_d = {cs_s_q[0], cs_n};
    si_s_d = {si_s_q[0], si};
    sck_old_d = sck_s_q[1];
    cs_old_d = cs_s_q[1];
    word_d = word_q;
    nbits_d = nbits_q;
    if (cs_s_q[1]) begin
      nbits_d = 6'h00;
    end else if (sck_s_q[1] && !sck_old_q && nbits_q < 6'h20) begin
      // msb first, mode 0/3 sample on rising edge
      word_d = {word_q[30:0], si_s_q[1]};
      nbits_d = nbits_q + 6'h01;
    end
  end

  assign cs_rise = cs_s_q[1] && !cs_old_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sck_s_q <= 2'h0;
      cs_s_q <= 2'h3;
      si_s_q <= 2'h0;
      sck_old_q <= 1'b0;
      cs_old_q <= 1'b1;
      word_q <= 32'h0;
      nbits_q <= 6'h00;
    end else begin
      sck_s_q <= sck_s_d;
      cs_s_q <= cs_s_d;
      si_s_q <= si_s_d;
      sck_old_q <= sck_old_d;
      cs_old_q <= cs_old_d;
      word_q <= word_d;
      nbits_q <= nbits_d;
    end
  end
endmodule

// file: core/sfe_erase_seq.sv
// Function
// - 264-byte page erase: 81h, four dummy, 11 page bits, nine dummy.
// - 256-byte page erase: 81h, five dummy, address bits 18..8, eight dummy.
// - chip select rise erases addressed page to ones within page time.
// - ready/busy reads busy throughout any erase.
// - failing byte during erase sets the erase/program error flag.
// - 264-byte block erase: 50h, four dummy, page bits 10..3, 12 dummy.
// - 256-byte block erase: 50h, five dummy, bits 18..11, 11 dummy.
// - chip select rise erases all eight block pages within block time.
// - block index is upper eight page bits; low three ignored.
// - 264-byte sector 0a/0b: 7Ch, four dummy, page bits 10..3, 12 dummy.
// - 264-byte sectors 1-7: 7Ch, four dummy, top three bits, 17 dummy.
// - 256-byte sector 0a/0b: 7Ch, five dummy, bits 18..11, 11 dummy.
// - 256-byte sectors 1-7: 7Ch, five dummy, bits 18..16, 16 dummy.
// - nine sectors; 0a/0b by upper eight bits, 1-7 by top three.
// - chip select rise erases whole sector 1-7, or the 8-page block in 0a/0b, sector time.
module sfe_erase_seq #(
  parameter int PAGE_ERASE_CYC = sfe_pkg::PAGE_ERASE_CYC,
  parameter int BLOCK_ERASE_CYC = sfe_pkg::BLOCK_ERASE_CYC,
  parameter int SECTOR_ERASE_CYC = sfe_pkg::SECTOR_ERASE_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic si,
  input wire logic page_264,
  input wire logic erase_fail,
  output logic busy,
  output logic erase_program_error_flag,
  output logic erase_pulse,
  output logic [10:0] erase_page_q,
  output logic clr_error
);
  logic [31:0] word;
  logic [5:0] nbits;
  logic cs_rise;

  sfe_shift_in u_shift (
    .clk(clk),
    .sys_rst(sys_rst),
    .sck(sck),
    .cs_n(cs_n),
    .si(si),
    .word_q(word),
    .nbits_q(nbits),
    .cs_rise(cs_rise)
  );

  typedef enum {ST_IDLE, ST_ERASE} sfe_state_type;
  sfe_state_type st_q, st_d;
  logic [sfe_pkg::CNT_W-1:0] tmr_q, tmr_d;
  logic [10:0] page_q, page_d;
  logic [11:0] left_q, left_d;
  logic err_q, err_d;
  logic [10:0] erase_page_d;
  logic [10:0] pnum;
  logic [7:0] opc;
  sfe_pkg::sfe_job_type job;

  // page number from address bytes; the dummy layout differs by page size
  function automatic logic [10:0] page_of(input logic [23:0] a,
                                          input logic p264);
    if (p264) begin
      page_of = a[sfe_pkg::PG_LSB_264 +: sfe_pkg::PAGE_BITS];
    end else begin
      page_of = a[sfe_pkg::PG_LSB_256 +: sfe_pkg::PAGE_BITS];
    end
  endfunction

  assign opc = word[31:24];
  assign pnum = page_of(word[23:0], page_264);

  always_comb begin
    job.op = sfe_pkg::SFE_OP_NONE;
    job.first_page = pnum;
    job.page_count = 12'h001;
    case (opc)
      sfe_pkg::OP_PAGE_ERASE: begin
        job.op = sfe_pkg::SFE_OP_PAGE;
      end
      sfe_pkg::OP_BLOCK_ERASE: begin
        // same bit slice serves both layouts
        job.op = sfe_pkg::SFE_OP_BLOCK;
        job.first_page = {pnum[10:3], 3'h0};
        job.page_count = 12'h008;
      end
      sfe_pkg::OP_SECTOR_ERASE: begin
        job.op = sfe_pkg::SFE_OP_SECTOR;
        if (pnum[10:8] == 3'h0) begin
          // sector 0a or 0b
          job.first_page = {pnum[10:3], 3'h0};
          job.page_count = 12'h008;
        end else begin
          // sectors 1-7: low bits are don't-care
          job.first_page = {pnum[10:8], 8'h00};
          job.page_count = 12'h100;
        end
      end
      default: begin
        job.op = sfe_pkg::SFE_OP_NONE;
      end
    endcase
  end

  always_comb begin
    st_d = st_q;
    tmr_d = tmr_q;
    page_d = page_q;
    left_d = left_q;
    err_d = err_q;
    erase_page_d = erase_page_q;
    erase_pulse = 1'b0;
    clr_error = 1'b0;
    case (st_q)
      ST_IDLE: begin
        // incomplete frames or unknown opcodes are dropped
        if (cs_rise && nbits == 6'(sfe_pkg::CMD_BITS) &&
            job.op != sfe_pkg::SFE_OP_NONE) begin
          st_d = ST_ERASE;
          page_d = job.first_page;
          left_d = job.page_count;
          err_d = 1'b0;
          clr_error = 1'b1;
          case (job.op)
            sfe_pkg::SFE_OP_PAGE:
              tmr_d = sfe_pkg::CNT_W'(PAGE_ERASE_CYC - 1);
            sfe_pkg::SFE_OP_BLOCK:
              tmr_d = sfe_pkg::CNT_W'(BLOCK_ERASE_CYC - 1);
            default:
              tmr_d = sfe_pkg::CNT_W'(SECTOR_ERASE_CYC - 1);
          endcase
        end
      end
      ST_ERASE: begin
        // one page per cycle wiped to ones, then wait out the self-time
        if (left_q != 12'h000) begin
          erase_pulse = 1'b1;
          erase_page_d = page_q;
          page_d = page_q + 11'h001;
          left_d = left_q - 12'h001;
        end
        if (erase_fail) begin
          err_d = 1'b1;
        end
        if (tmr_q == '0) begin
          st_d = ST_IDLE;
        end else begin
          tmr_d = tmr_q - sfe_pkg::CNT_W'(1);
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
  end

  assign busy = (st_q == ST_ERASE);
  assign erase_program_error_flag = err_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q <= ST_IDLE;
      tmr_q <= '0;
      page_q <= 11'h000;
      left_q <= 12'h000;
      err_q <= 1'b0;
      erase_page_q <= 11'h000;
    end else begin
      st_q <= st_d;
      tmr_q <= tmr_d;
      page_q <= page_d;
      left_q <= left_d;
      err_q <= err_d;
      erase_page_q <= erase_page_d;
    end
  end

  property p_busy_start;
    @(posedge clk) disable iff (sys_rst)
    (st_q == ST_IDLE && cs_rise && nbits == 6'h20 &&
     job.op != sfe_pkg::SFE_OP_NONE) |=> busy;
  endproperty
  a_busy_start: assert property (p_busy_start)
    else $error("erase did not go busy");

  property p_busy_hold;
    @(posedge clk) disable iff (sys_rst)
    $rose(busy) |-> busy [*8];
  endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("busy dropped early");

  property p_page_one;
    @(posedge clk) disable iff (sys_rst)
    (st_q == ST_IDLE && cs_rise && nbits == 6'h20 &&
     opc == sfe_pkg::OP_PAGE_ERASE) |=> erase_pulse ##1 !erase_pulse;
  endproperty
  a_page_one: assert property (p_page_one)
    else $error("page erase count wrong");

  property p_block_eight;
    @(posedge clk) disable iff (sys_rst)
    (st_q == ST_IDLE && cs_rise && nbits == 6'h20 &&
     opc == sfe_pkg::OP_BLOCK_ERASE) |=> erase_pulse [*8] ##1 !erase_pulse;
  endproperty
  a_block_eight: assert property (p_block_eight)
    else $error("block erase not eight pages");

  property p_block_align;
    @(posedge clk) disable iff (sys_rst)
    (st_q == ST_IDLE && cs_rise && opc == sfe_pkg::OP_BLOCK_ERASE)
      |-> job.first_page[2:0] == 3'h0;
  endproperty
  a_block_align: assert property (p_block_align)
    else $error("block start not aligned");

  property p_sector_start;
    @(posedge clk) disable iff (sys_rst)
    (st_q == ST_IDLE && cs_rise && opc == sfe_pkg::OP_SECTOR_ERASE &&
     pnum[10:8] != 3'h0) |-> job.first_page == {pnum[10:8], 8'h00};
  endproperty
  a_sector_start: assert property (p_sector_start)
    else $error("sector start wrong");

  property p_err_set;
    @(posedge clk) disable iff (sys_rst)
    (busy && erase_fail) |=> erase_program_error_flag;
  endproperty
  a_err_set: assert property (p_err_set)
    else $error("erase error not flagged");

  property p_page_pick;
    @(posedge clk) disable iff (sys_rst)
    (page_264 && cs_rise) |-> pnum == word[19:9];
  endproperty
  a_page_pick: assert property (p_page_pick)
    else $error("page bits mis-sliced");
endmodule

// file: bench/sfe_host_model.sv
// host side: shifts the top len bits of one 32-bit command per chip-select frame
module sfe_host_model (
  input wire logic clk,
  input wire logic busy,
  output logic sck,
  output logic cs_n,
  output logic si
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // gap lets the host answer promptly or slowly
  // len below 32 cuts the frame short, which the block must drop
  task automatic send(input logic [31:0] word, input int gap,
                      input int len = 32);
    hold(gap);
    while (busy !== 1'b0) hold(1);
    cs_n = 1'b0;
    // four clocks per half of the 80 ns link period
    for (int i = 31; i > 31 - len; i--) begin
      si = word[i];
      hold(4);
      sck = 1'b1;
      hold(4);
      sck = 1'b0;
    end
    hold(4);
    cs_n = 1'b1;
    // released line must not keep showing the last bit
    si = ~si;
  endtask
endmodule

// file: bench/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PE_CYC = 16;
  localparam int BE_CYC = 16;
  localparam int SE_CYC = 300;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic page_264 = 1'b0;
  logic erase_fail = 1'b0;
  logic sck, cs_n, si, busy, err_flag, pulse;
  logic [10:0] page_q;
  logic pend = 1'b0;
  logic clr;
  int clr_count = 0;
  logic [31:0] r;
  logic [10:0] exp_q[$];
  int miscompares = 0;
  int tests_run = 0;
  int cycles = 0;
  int seed = 28956;
  always #5 clk = ~clk;
  sfe_erase_seq #(
    .PAGE_ERASE_CYC(PE_CYC),
    .BLOCK_ERASE_CYC(BE_CYC),
    .SECTOR_ERASE_CYC(SE_CYC)
  ) dut (
    .clk(clk),
    .sys_rst(sys_rst),
    .sck(sck),
    .cs_n(cs_n),
    .si(si),
    .page_264(page_264),
    .erase_fail(erase_fail),
    .busy(busy),
    .erase_program_error_flag(err_flag),
    .erase_pulse(pulse),
    .erase_page_q(page_q),
    .clr_error(clr)
  );
  sfe_host_model host (
    .clk(clk),
    .busy(busy),
    .sck(sck),
    .cs_n(cs_n),
    .si(si)
  );
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("compares=%0d mismatches=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // page register is valid one cycle after the pulse
  always @(negedge clk) begin
    if (pend) begin
      if (exp_q.size() == 0) check(32'h1, 32'h0);
      else check(page_q, exp_q.pop_front());
    end
    if (clr) clr_count++;
    pend = pulse;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      results();
    end
  end
  task automatic run(input logic [7:0] op, input logic [10:0] pg,
      input logic p264, input logic fail);
    int n;
    int lo;
    int cyc;
    int c0;
    logic [23:0] addr;
    page_264 = p264;
    c0 = clr_count;
    addr = p264 ? {4'h0, pg, 9'h000} : {5'h00, pg, 8'h00};
    lo = pg;
    n = 1;
    cyc = PE_CYC;
    if (op == sfe_pkg::OP_BLOCK_ERASE) cyc = BE_CYC;
    if (op == sfe_pkg::OP_SECTOR_ERASE) cyc = SE_CYC;
    if (op != sfe_pkg::OP_PAGE_ERASE) begin
      lo = pg & 11'h7f8;
      n = 8;
    end
    if (op == sfe_pkg::OP_SECTOR_ERASE && pg[10:8] != 3'h0) begin
      lo = {pg[10:8], 8'h00};
      n = 256;
    end
    for (int i = 0; i < n; i++) exp_q.push_back(11'(lo + i));
    host.send({op, addr}, $random(seed) & 7);
    n = 0;
    while (busy !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(busy, 1'b1);
    erase_fail = fail;
    n = 0;
    while (busy === 1'b1 && n < 2000) begin
      @(posedge clk);
      #1;
      n++;
    end
    erase_fail = 1'b0;
    check(n, cyc);
    check(clr_count - c0, 1);
    check(err_flag, fail);
    check(exp_q.size(), 0);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    for (int k = 0; k < 8; k++) begin
      r = $random(seed);
      run(sfe_pkg::OP_PAGE_ERASE, r[10:0], k[0], k == 3);
      run(sfe_pkg::OP_BLOCK_ERASE, r[21:11], k[0], 1'b0);
      run(sfe_pkg::OP_SECTOR_ERASE,
          (k == 0) ? {8'h00, r[26:24]} : {k[2:0], r[31:24]}, k[1], 1'b0);
    end
    run(sfe_pkg::OP_SECTOR_ERASE, {8'h01, r[2:0]}, 1'b1, 1'b0);
    // an unknown opcode must not start an erase
    host.send(32'h03000000, 0);
    repeat (8) @(posedge clk);
    #1;
    check(busy, 1'b0);
    // a frame cut short is dropped
    host.send({sfe_pkg::OP_PAGE_ERASE, r[23:0]}, 0, 24);
    repeat (8) @(posedge clk);
    #1;
    check(busy, 1'b0);
    // 25 accepted erases, none from the two dropped frames
    check(clr_count, 32'h19);
    results();
  end
endmodule
